// ---- verilog/pcsia_defs.svh ----
// Constants of the program-flow and indirect-addressing unit
// Summary of operation
// R01: Low byte write loads upper bits from latch
// R02: Call takes operand plus latch bits 6:3
// R03: Indirect call uses accumulator and full latch
// R04: Accumulator jump: incremented PC plus unsigned offset
// R05: Relative jump: incremented PC plus signed operand
// R06: Sixteen entry fifteen bit private return stack
// R07: Calls and interrupts push; returns pop; latch kept
// R08: Fault reset off: stack wraps circularly
// R09: Overflow and underflow flags always set
// R10: Five bit pointer; top entry bytes accessible
// R11: Push increments then writes; pop reads then decrements
// R12: Pointer 0x1F is empty; first push gives 0
// R13: Fault reset on: overflow or underflow resets
// R14: Indirect port targeting itself reads zero, drops write
// R15: Pointer pair forms sixteen bit address
// R16: Low 4K pointer addresses map one to one
// R17: Linear region maps onto banked 80 byte blocks
// R18: Unimplemented locations read as zero
// R19: Pointer MSB selects flash, low byte returned
// R20: Indirect writes never alter flash
// R21: Flash access takes one extra cycle
// R22: Every reset clears the program counter
// R23: Linear offset divided by 80 gives bank
// R24: Top entry writes keep the pointer still
`ifndef PCSIA_DEFS_SVH
`define PCSIA_DEFS_SVH
`define PCSIA_PC_W 15
`define PCSIA_REG_PC_LOW 4'h0
`define PCSIA_REG_PC_LATCH 4'h1
`define PCSIA_REG_STK_PTR 4'h2
`define PCSIA_REG_TOP_LOW 4'h3
`define PCSIA_REG_TOP_HIGH 4'h4
`define PCSIA_REG_PTR0_LOW 4'h5
`define PCSIA_REG_PTR0_HIGH 4'h6
`define PCSIA_REG_PTR1_LOW 4'h7
`define PCSIA_REG_PTR1_HIGH 4'h8
`define PCSIA_REG_PWR_STAT 4'h9
`define PCSIA_PWR_OVF_BIT 1
`define PCSIA_PWR_UNF_BIT 0
`define PCSIA_STK_EMPTY 5'h1F
`define PCSIA_STK_LAST 5'h0F
`define PCSIA_INT_VECTOR 15'h0004
`define PCSIA_LIN_BASE 16'h2000
`define PCSIA_LIN_LAST 16'h29AF
`define PCSIA_TRAD_LAST 16'h0FFF
`define PCSIA_GPR_BYTES 12'h050
`define PCSIA_GPR_START 7'h20
`define PCSIA_IND_PORT0 7'h00
`define PCSIA_IND_PORT1 7'h01
`endif

// ---- verilog/pcsia_pkg.sv ----
// Types shared by the program-flow and indirect-addressing unit
`default_nettype none
package pcsia_pkg;
  typedef enum logic [3:0] {PCSIA_OP_NONE, PCSIA_OP_INC, PCSIA_OP_WR_LOW, PCSIA_OP_CALL, PCSIA_OP_INDIRECT_SUBROUTINE_INSTR,
    PCSIA_OP_BRW, PCSIA_OP_BRA, PCSIA_OP_RETURN, PCSIA_OP_RETURN_WITH_LITERAL_INSTR, PCSIA_OP_INTERRUPT_EXIT_INSTR, PCSIA_OP_INTV} pcsia_op_e;
  typedef struct packed {
    logic valid;
    pcsia_op_e op;
    logic [10:0] operand;
    logic [7:0] wreg;
  } pcsia_cmd_s;
  typedef struct packed {
    logic valid;
    logic sel;
    logic write;
    logic [7:0] wdata;
  } pcsia_ind_req_s;
  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } pcsia_ind_rsp_s;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcsia_dmem_s;
  typedef enum logic [1:0] {PCSIA_TGT_DATA, PCSIA_TGT_NULL, PCSIA_TGT_FLASH} pcsia_tgt_e;
endpackage : pcsia_pkg
`default_nettype wire

// ---- verilog/pcsia_unit.sv ----
// Program counter, return stack and indirect addressing unit
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pcsia_defs.svh"
module pcsia_unit (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Configuration
  input wire logic i_stack_fault_reset_en,
  // Instruction execution commands
  input wire pcsia_pkg::pcsia_cmd_s i_cmd,
  input wire pcsia_pkg::pcsia_ind_req_s i_ind_req,
  output pcsia_pkg::pcsia_ind_rsp_s o_ind_rsp,
  output logic o_ind_busy,
  output logic [14:0] o_pc,
  output logic o_stack_fault_reset,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Data memory and flash
  output pcsia_pkg::pcsia_dmem_s o_dmem,
  input wire logic [7:0] i_dmem_rdata,
  output logic [14:0] o_flash_addr,
  output logic o_flash_rd,
  input wire logic [13:0] i_flash_rdata
);
  import pcsia_pkg::*;

  typedef enum {PCSIA_IND_IDLE, PCSIA_IND_ISSUE, PCSIA_IND_WAIT, PCSIA_IND_EXTRA} pcsia_ind_state_e;

  logic [14:0] pc_q;
  logic [6:0] latch_q;
  logic [4:0] stk_ptr_q;
  logic [14:0] stack_q [16];
  logic [7:0] ptr_low_q [2];
  logic [7:0] ptr_high_q [2];
  logic ovf_q;
  logic unf_q;
  logic fault_q;
  pcsia_ind_state_e ind_state_q;
  pcsia_tgt_e tgt_q;
  logic [7:0] rdata_hold_q;
  pcsia_ind_rsp_s ind_rsp_q;
  logic ind_busy_q;
  pcsia_dmem_s dmem_q;
  logic [14:0] flash_addr_q;
  logic flash_rd_q;
  logic [7:0] reg_rdata_q;

  logic cmd_push;
  logic cmd_pop;
  logic push_ovf;
  logic pop_unf;
  logic stk_fault;
  logic [14:0] pc_inc;
  logic [14:0] tos;
  logic bus_pc_low_wr;
  logic ind_accept;
  logic [15:0] ind_ptr;
  pcsia_tgt_e ind_tgt;
  logic [11:0] ind_daddr;
  logic [11:0] lin_off;
  logic [11:0] lin_bank;
  logic [11:0] lin_rem;
  logic [7:0] reg_rd_mux;

  assign pc_inc = 15'(pc_q + 15'h0001);
  assign tos = stack_q[stk_ptr_q[3:0]];
  assign cmd_push = i_cmd.valid && (i_cmd.op inside {PCSIA_OP_CALL, PCSIA_OP_INDIRECT_SUBROUTINE_INSTR, PCSIA_OP_INTV}); // R07
  assign cmd_pop = i_cmd.valid && (i_cmd.op inside {PCSIA_OP_RETURN, PCSIA_OP_RETURN_WITH_LITERAL_INSTR, PCSIA_OP_INTERRUPT_EXIT_INSTR}); // R07
  // Past the last entry the pointer keeps climbing; pushes from 0x0F through 0x1E count as overflow, a push from 0x1F does not
  assign push_ovf = cmd_push && (stk_ptr_q >= `PCSIA_STK_LAST) && (stk_ptr_q != `PCSIA_STK_EMPTY);
  assign pop_unf = cmd_pop && (stk_ptr_q == `PCSIA_STK_EMPTY);
  assign stk_fault = i_stack_fault_reset_en && (push_ovf || pop_unf); // R13
  assign bus_pc_low_wr = i_reg_wr && (i_reg_addr == `PCSIA_REG_PC_LOW);

  // Program counter; a CPU command wins over a bus write of the low byte
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pc_q <= 15'h0000; // R22
    else if (i_clk_en)
    begin
      if (stk_fault)
        pc_q <= 15'h0000; // R22
      else if (i_cmd.valid)
      begin
        unique case (i_cmd.op)
          PCSIA_OP_NONE: pc_q <= pc_q;
          PCSIA_OP_INC: pc_q <= pc_inc;
          PCSIA_OP_WR_LOW: pc_q <= {latch_q, i_cmd.wreg}; // R01
          PCSIA_OP_CALL: pc_q <= {latch_q[6:3], i_cmd.operand}; // R02
          PCSIA_OP_INDIRECT_SUBROUTINE_INSTR: pc_q <= {latch_q, i_cmd.wreg}; // R03
          PCSIA_OP_BRW: pc_q <= 15'(pc_inc + {7'h00, i_cmd.wreg}); // R04
          PCSIA_OP_BRA: pc_q <= 15'(pc_inc + {{6{i_cmd.operand[8]}}, i_cmd.operand[8:0]}); // R05
          PCSIA_OP_RETURN, PCSIA_OP_RETURN_WITH_LITERAL_INSTR, PCSIA_OP_INTERRUPT_EXIT_INSTR: pc_q <= tos; // R11
          PCSIA_OP_INTV: pc_q <= `PCSIA_INT_VECTOR;
          default: pc_q <= pc_q;
        endcase
      end
      else if (bus_pc_low_wr)
        pc_q <= {latch_q, i_reg_wdata}; // R01
    end
  end

  // Upper latch: only software writes it, stack traffic leaves it alone
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      latch_q <= 7'h00;
    else if (i_clk_en && i_reg_wr && (i_reg_addr == `PCSIA_REG_PC_LATCH))
      latch_q <= i_reg_wdata[6:0]; // R07
  end

  // Stack pointer: push increments first, pop decrements after the read
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      stk_ptr_q <= `PCSIA_STK_EMPTY; // R12
    else if (i_clk_en)
    begin
      if (stk_fault)
        stk_ptr_q <= `PCSIA_STK_EMPTY; // R13
      else if (cmd_push)
        stk_ptr_q <= 5'(stk_ptr_q + 5'h01); // R11 R12 R08
      else if (cmd_pop)
        stk_ptr_q <= 5'(stk_ptr_q - 5'h01); // R11
      else if (i_reg_wr && (i_reg_addr == `PCSIA_REG_STK_PTR))
        stk_ptr_q <= i_reg_wdata[4:0]; // R10
    end
  end

  // Return stack entries; low four pointer bits index them so a wrapped push overwrites the oldest
  generate
    for (genvar e = 0; e < 16; e++)
    begin : g_stack
      always_ff @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
          stack_q[e] <= 15'h0000;
        else if (i_clk_en)
        begin
          if (cmd_push && !stk_fault && (4'(stk_ptr_q + 5'h01) == 4'(e)))
            stack_q[e] <= (i_cmd.op == PCSIA_OP_INTV) ? pc_q : pc_inc; // R06 R08 R11
          else if (!cmd_push && !cmd_pop && (stk_ptr_q[3:0] == 4'(e)) && i_reg_wr)
          begin
            if (i_reg_addr == `PCSIA_REG_TOP_LOW)
              stack_q[e][7:0] <= i_reg_wdata; // R10 R24
            else if (i_reg_addr == `PCSIA_REG_TOP_HIGH)
              stack_q[e][14:8] <= i_reg_wdata[6:0]; // R10 R24
          end
        end
      end
    end
  endgenerate

  // Flags are sticky; a hardware set beats a software clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (i_reg_wr && (i_reg_addr == `PCSIA_REG_PWR_STAT))
      begin
        ovf_q <= i_reg_wdata[`PCSIA_PWR_OVF_BIT] || push_ovf; // R09
        unf_q <= i_reg_wdata[`PCSIA_PWR_UNF_BIT] || pop_unf; // R09
      end
      else
      begin
        ovf_q <= ovf_q || push_ovf; // R09
        unf_q <= unf_q || pop_unf; // R09
      end
      fault_q <= stk_fault; // R13
    end
  end

  // File pointer pairs, software written
  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_ptr
      always_ff @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          ptr_low_q[p] <= 8'h00;
          ptr_high_q[p] <= 8'h00;
        end
        else if (i_clk_en && i_reg_wr)
        begin
          if (i_reg_addr == 4'(`PCSIA_REG_PTR0_LOW + 4'(2 * p)))
            ptr_low_q[p] <= i_reg_wdata;
          if (i_reg_addr == 4'(`PCSIA_REG_PTR0_HIGH + 4'(2 * p)))
            ptr_high_q[p] <= i_reg_wdata;
        end
      end
    end
  endgenerate

  // Address decode for an indirect access
  assign ind_ptr = {ptr_high_q[i_ind_req.sel], ptr_low_q[i_ind_req.sel]}; // R15
  assign lin_off = 12'(ind_ptr - `PCSIA_LIN_BASE);
  assign lin_bank = lin_off / `PCSIA_GPR_BYTES; // R23
  assign lin_rem = lin_off % `PCSIA_GPR_BYTES; // R23

  always_comb
  begin
    ind_tgt = PCSIA_TGT_NULL; // R18
    ind_daddr = 12'h000;
    if (ind_ptr[15])
      ind_tgt = PCSIA_TGT_FLASH; // R19
    else if (ind_ptr <= `PCSIA_TRAD_LAST)
    begin
      ind_daddr = ind_ptr[11:0]; // R16
      // An indirect port pointing at itself would recurse, so it becomes a null access
      if ((ind_ptr[6:0] == `PCSIA_IND_PORT0) || (ind_ptr[6:0] == `PCSIA_IND_PORT1))
        ind_tgt = PCSIA_TGT_NULL; // R14
      else
        ind_tgt = PCSIA_TGT_DATA;
    end
    else if ((ind_ptr >= `PCSIA_LIN_BASE) && (ind_ptr <= `PCSIA_LIN_LAST))
    begin
      ind_tgt = PCSIA_TGT_DATA;
      ind_daddr = {lin_bank[4:0], 7'(`PCSIA_GPR_START + lin_rem[6:0])}; // R17 R23
    end
  end

  assign ind_accept = i_ind_req.valid && (ind_state_q == PCSIA_IND_IDLE);

  // Indirect access sequencer; requests while busy are dropped
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ind_state_q <= PCSIA_IND_IDLE;
      tgt_q <= PCSIA_TGT_NULL;
      rdata_hold_q <= 8'h00;
      ind_rsp_q <= '0;
      ind_busy_q <= 1'b0;
      dmem_q <= '0;
      flash_addr_q <= 15'h0000;
      flash_rd_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      ind_rsp_q.done <= 1'b0;
      dmem_q.wr <= 1'b0;
      dmem_q.rd <= 1'b0;
      flash_rd_q <= 1'b0;
      unique case (ind_state_q)
        PCSIA_IND_IDLE:
          if (ind_accept)
          begin
            ind_state_q <= PCSIA_IND_ISSUE;
            ind_busy_q <= 1'b1;
            tgt_q <= ind_tgt;
            dmem_q.addr <= ind_daddr;
            dmem_q.wdata <= i_ind_req.wdata;
            dmem_q.wr <= (ind_tgt == PCSIA_TGT_DATA) && i_ind_req.write; // R14
            dmem_q.rd <= (ind_tgt == PCSIA_TGT_DATA) && !i_ind_req.write;
            flash_addr_q <= ind_ptr[14:0]; // R19
            flash_rd_q <= (ind_tgt == PCSIA_TGT_FLASH) && !i_ind_req.write; // R20
          end
        PCSIA_IND_ISSUE:
          ind_state_q <= PCSIA_IND_WAIT;
        PCSIA_IND_WAIT:
        begin
          unique case (tgt_q)
            PCSIA_TGT_DATA: rdata_hold_q <= i_dmem_rdata;
            PCSIA_TGT_FLASH: rdata_hold_q <= i_flash_rdata[7:0]; // R19
            default: rdata_hold_q <= 8'h00; // R14 R18
          endcase
          if (tgt_q == PCSIA_TGT_FLASH)
            ind_state_q <= PCSIA_IND_EXTRA; // R21
          else
          begin
            ind_state_q <= PCSIA_IND_IDLE;
            ind_busy_q <= 1'b0;
            ind_rsp_q.done <= 1'b1;
            ind_rsp_q.rdata <= (tgt_q == PCSIA_TGT_DATA) ? i_dmem_rdata : 8'h00; // R14 R18
          end
        end
        PCSIA_IND_EXTRA:
        begin
          ind_state_q <= PCSIA_IND_IDLE;
          ind_busy_q <= 1'b0;
          ind_rsp_q.done <= 1'b1;
          ind_rsp_q.rdata <= rdata_hold_q; // R21
        end
      endcase
    end
  end

  // Register read mux
  always_comb
  begin
    unique case (i_reg_addr)
      `PCSIA_REG_PC_LOW: reg_rd_mux = pc_q[7:0];
      `PCSIA_REG_PC_LATCH: reg_rd_mux = {1'b0, latch_q};
      `PCSIA_REG_STK_PTR: reg_rd_mux = {3'h0, stk_ptr_q}; // R10
      `PCSIA_REG_TOP_LOW: reg_rd_mux = tos[7:0]; // R10
      `PCSIA_REG_TOP_HIGH: reg_rd_mux = {1'b0, tos[14:8]}; // R10
      `PCSIA_REG_PTR0_LOW: reg_rd_mux = ptr_low_q[0];
      `PCSIA_REG_PTR0_HIGH: reg_rd_mux = ptr_high_q[0];
      `PCSIA_REG_PTR1_LOW: reg_rd_mux = ptr_low_q[1];
      `PCSIA_REG_PTR1_HIGH: reg_rd_mux = ptr_high_q[1];
      `PCSIA_REG_PWR_STAT: reg_rd_mux = {6'h00, ovf_q, unf_q};
      default: reg_rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      reg_rdata_q <= 8'h00;
    else if (i_clk_en)
      reg_rdata_q <= i_reg_rd ? reg_rd_mux : 8'h00;
  end

  assign o_pc = pc_q;
  assign o_ind_rsp = ind_rsp_q;
  assign o_ind_busy = ind_busy_q;
  assign o_stack_fault_reset = fault_q;
  assign o_reg_rdata = reg_rdata_q;
  assign o_dmem = dmem_q;
  assign o_flash_addr = flash_addr_q;
  assign o_flash_rd = flash_rd_q;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_ind_data_acc;
    i_clk_en && ind_accept && (ind_tgt != PCSIA_TGT_FLASH);
  endsequence
  sequence s_ind_flash_acc;
    i_clk_en && ind_accept && (ind_tgt == PCSIA_TGT_FLASH);
  endsequence

  property p_pc_low_write;
    i_clk_en && bus_pc_low_wr && !i_cmd.valid && !stk_fault |=> pc_q == {$past(latch_q), $past(i_reg_wdata)};
  endproperty
  a_pc_low_write: assert property (p_pc_low_write) else $error("low byte write did not load latch"); // R01

  property p_call;
    i_clk_en && i_cmd.valid && i_cmd.op == PCSIA_OP_CALL && !stk_fault
      |=> pc_q == {$past(latch_q[6:3]), $past(i_cmd.operand)} && stack_q[stk_ptr_q[3:0]] == $past(pc_inc);
  endproperty
  a_call: assert property (p_call) else $error("call target or return address wrong"); // R02

  property p_indirect_subroutine_instr;
    i_clk_en && i_cmd.valid && i_cmd.op == PCSIA_OP_INDIRECT_SUBROUTINE_INSTR && !stk_fault
      |=> pc_q == {$past(latch_q), $past(i_cmd.wreg)} && latch_q == $past(latch_q);
  endproperty
  a_indirect_subroutine_instr: assert property (p_indirect_subroutine_instr) else $error("indirect call target wrong"); // R03

  property p_brw;
    i_clk_en && i_cmd.valid && i_cmd.op == PCSIA_OP_BRW |=> pc_q == 15'($past(pc_q) + 15'h0001 + $past(i_cmd.wreg));
  endproperty
  a_brw: assert property (p_brw) else $error("accumulator jump target wrong"); // R04

  property p_bra;
    i_clk_en && i_cmd.valid && i_cmd.op == PCSIA_OP_BRA && i_cmd.operand[8:0] == 9'h1FF |=> pc_q == $past(pc_q);
  endproperty
  a_bra: assert property (p_bra) else $error("relative jump by minus one did not hold"); // R05

  property p_first_push;
    i_clk_en && cmd_push && stk_ptr_q == `PCSIA_STK_EMPTY |=> stk_ptr_q == 5'h00;
  endproperty
  a_first_push: assert property (p_first_push) else $error("first push did not give pointer zero"); // R12

  property p_overflow;
    i_clk_en && cmd_push && stk_ptr_q == `PCSIA_STK_LAST |=> ovf_q && (i_stack_fault_reset_en || stk_ptr_q == 5'h10);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged or pointer wrong"); // R09

  property p_fault;
    i_clk_en && stk_fault |=> o_stack_fault_reset && pc_q == 15'h0000 && stk_ptr_q == `PCSIA_STK_EMPTY;
  endproperty
  a_fault: assert property (p_fault) else $error("stack fault did not reset"); // R13

  property p_data_timing;
    s_ind_data_acc ##1 i_clk_en [*2] |=> o_ind_rsp.done && !o_ind_busy;
  endproperty
  a_data_timing: assert property (p_data_timing) else $error("data indirect access not done in three cycles"); // R14

  property p_flash_timing;
    s_ind_flash_acc ##1 i_clk_en [*2] |=> !o_ind_rsp.done ##0 i_clk_en |=> o_ind_rsp.done;
  endproperty
  a_flash_timing: assert property (p_flash_timing) else $error("flash access lacks its extra cycle"); // R21

endmodule : pcsia_unit
`default_nettype wire

// ---- tb/pcsia_mem_model.sv ----
// Behavioural data memory and read-only program flash facing the unit
`timescale 1ns/100ps
`default_nettype none
module pcsia_mem_model (
  // Clock
  input wire logic i_sys_clk,
  // Data memory side
  input wire pcsia_pkg::pcsia_dmem_s i_dmem,
  output logic [7:0] o_dmem_rdata,
  output logic [15:0] o_wr_count,
  // Flash side
  input wire logic [14:0] i_flash_addr,
  input wire logic i_flash_rd,
  output logic [13:0] o_flash_rdata
);
  import pcsia_pkg::*;
  logic [7:0] mem_q [0:4095];
  initial
  begin
    for (int i = 0; i < 4096; i++)
    begin
      mem_q[i] = 8'(i) ^ {4'(i >> 8), 4'h0};
    end
    o_dmem_rdata = 8'h00;
    o_flash_rdata = 14'h0000;
    o_wr_count = 16'h0000;
  end
  // Data stands only in the cycle after a strobe; otherwise it toggles so stale data never matches
  always @(posedge i_sys_clk)
  begin
    if (i_dmem.rd)
      o_dmem_rdata <= mem_q[i_dmem.addr];
    else
      o_dmem_rdata <= ~o_dmem_rdata;
    if (i_dmem.wr)
    begin
      mem_q[i_dmem.addr] <= i_dmem.wdata;
      o_wr_count <= o_wr_count + 16'h0001;
    end
  end
  // Flash has no write path at all, it is a fixed pattern of the address
  always @(posedge i_sys_clk)
  begin
    if (i_flash_rd)
      o_flash_rdata <= {i_flash_addr[5:0], i_flash_addr[7:0] ^ 8'h3C};
    else
      o_flash_rdata <= ~o_flash_rdata;
  end
endmodule : pcsia_mem_model
`default_nettype wire

// ---- tb/pcsia_unit_bench.sv ----
// Self-checking bench of the program counter, stack and indirect unit
`timescale 1ns/100ps
`default_nettype none
`include "pcsia_defs.svh"
module pcsia_unit_bench;
  import pcsia_pkg::*;
  logic clk, rst_n, clk_en, fault_en, reg_wr, reg_rd, flash_rd, stk_fault, fault_seen, ind_busy;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dmem_rdata;
  logic [14:0] pc, flash_addr;
  logic [13:0] flash_rdata;
  logic [15:0] wr_count, wr_before;
  pcsia_cmd_s cmd;
  pcsia_ind_req_s ind_req;
  pcsia_ind_rsp_s ind_rsp;
  pcsia_dmem_s dmem;
  int n_fail, samples_checked;
  pcsia_unit DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_stack_fault_reset_en(fault_en),
    .i_cmd(cmd), .i_ind_req(ind_req), .o_ind_rsp(ind_rsp), .o_ind_busy(ind_busy), .o_pc(pc),
    .o_stack_fault_reset(stk_fault), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_dmem(dmem), .i_dmem_rdata(dmem_rdata),
    .o_flash_addr(flash_addr), .o_flash_rd(flash_rd), .i_flash_rdata(flash_rdata));
  pcsia_mem_model mem (.i_sys_clk(clk), .i_dmem(dmem), .o_dmem_rdata(dmem_rdata), .o_wr_count(wr_count),
    .i_flash_addr(flash_addr), .i_flash_rd(flash_rd), .o_flash_rdata(flash_rdata));
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("register read", {8'h00, exp}, {8'h00, reg_rdata});
  endtask : reg_check
  // Each command is a single cycle; the pc and the fault pulse are looked at in the cycle after
  task automatic run(input pcsia_op_e op, input logic [10:0] opd, input logic [7:0] w, input logic [14:0] exp);
    @(posedge clk);
    cmd <= '{valid: 1'b1, op: op, operand: opd, wreg: w};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1 fault_seen = stk_fault;
    check("program counter", {1'b0, exp}, {1'b0, pc});
  endtask : run
  function automatic logic [7:0] mem_init(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h0};
  endfunction : mem_init
  task automatic access(input logic sel, input logic [15:0] ptr, input logic wr, input logic [7:0] d,
    input logic [7:0] exp, input logic [15:0] lat);
    logic [15:0] n;
    reg_write(sel ? `PCSIA_REG_PTR1_LOW : `PCSIA_REG_PTR0_LOW, ptr[7:0]);
    reg_write(sel ? `PCSIA_REG_PTR1_HIGH : `PCSIA_REG_PTR0_HIGH, ptr[15:8]);
    @(posedge clk);
    ind_req <= '{valid: 1'b1, sel: sel, write: wr, wdata: d};
    @(posedge clk);
    ind_req.valid <= 1'b0;
    #1 check("indirect busy", 16'h0001, {15'h0000, ind_busy});
    n = 16'h0000;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (ind_rsp.done !== 1'b1 && n < 16'h0008);
    if (ind_rsp.done !== 1'b1)
    begin
      n_fail++;
      summarize();
    end
    check("indirect latency", lat, n);
    check("indirect idle", 16'h0000, {15'h0000, ind_busy});
    if (!wr)
      check("indirect data", {8'h00, exp}, {8'h00, ind_rsp.rdata});
  endtask : access
  task automatic t_reset();
    check("reset pc", 16'h0000, {1'b0, pc});
    reg_check(`PCSIA_REG_STK_PTR, 8'h1F);
    reg_check(`PCSIA_REG_PWR_STAT, 8'h00);
  endtask : t_reset
  task automatic t_pc_flow();
    reg_write(`PCSIA_REG_PC_LATCH, 8'h08);
    run(PCSIA_OP_CALL, 11'h123, 8'h00, 15'h0923);
    reg_check(`PCSIA_REG_STK_PTR, 8'h00);
    reg_check(`PCSIA_REG_TOP_LOW, 8'h01);
    reg_check(`PCSIA_REG_TOP_HIGH, 8'h00);
    reg_write(`PCSIA_REG_PC_LOW, 8'h34);
    #1 check("pc after low write", 16'h0834, {1'b0, pc});
    // A bus write with the enable low must leave every flop alone
    @(posedge clk);
    clk_en <= 1'b0;
    reg_write(`PCSIA_REG_PC_LOW, 8'h99);
    #1 check("pc while frozen", 16'h0834, {1'b0, pc});
    @(posedge clk);
    clk_en <= 1'b1;
    run(PCSIA_OP_INDIRECT_SUBROUTINE_INSTR, 11'h000, 8'h56, 15'h0856);
    run(PCSIA_OP_BRW, 11'h000, 8'hF0, 15'h0947);
    run(PCSIA_OP_BRA, 11'h1F0, 8'h00, 15'h0938);
    run(PCSIA_OP_BRA, 11'h1FF, 8'h00, 15'h0938);
    run(PCSIA_OP_RETURN, 11'h000, 8'h00, 15'h0835);
    reg_check(`PCSIA_REG_STK_PTR, 8'h00);
    run(PCSIA_OP_RETURN_WITH_LITERAL_INSTR, 11'h000, 8'h00, 15'h0001);
    reg_check(`PCSIA_REG_STK_PTR, 8'h1F);
    reg_check(`PCSIA_REG_PC_LATCH, 8'h08);
    run(PCSIA_OP_INTV, 11'h000, 8'h00, 15'h0004);
    reg_check(`PCSIA_REG_TOP_LOW, 8'h01);
    run(PCSIA_OP_INTERRUPT_EXIT_INSTR, 11'h000, 8'h00, 15'h0001);
  endtask : t_pc_flow
  task automatic t_stack_wrap();
    reg_write(`PCSIA_REG_PC_LATCH, 8'h00);
    @(posedge clk);
    cmd <= '{valid: 1'b1, op: PCSIA_OP_INTERRUPT_EXIT_INSTR, operand: 11'h000, wreg: 8'h00};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1 check("no fault when disabled", 16'h0000, {15'h0000, stk_fault});
    reg_check(`PCSIA_REG_PWR_STAT, 8'h01);
    reg_write(`PCSIA_REG_PWR_STAT, 8'h00);
    reg_write(`PCSIA_REG_STK_PTR, 8'h1F);
    for (int i = 0; i < 17; i++)
      run(PCSIA_OP_CALL, 11'(2 * i), 8'h00, 15'(2 * i));
    reg_check(`PCSIA_REG_PWR_STAT, 8'h02);
    reg_write(`PCSIA_REG_STK_PTR, 8'h00);
    reg_check(`PCSIA_REG_TOP_LOW, 8'h1F);
    reg_write(`PCSIA_REG_STK_PTR, 8'h01);
    reg_check(`PCSIA_REG_TOP_LOW, 8'h01);
  endtask : t_stack_wrap
  task automatic t_top_entry();
    reg_write(`PCSIA_REG_STK_PTR, 8'h05);
    reg_write(`PCSIA_REG_TOP_LOW, 8'hAB);
    reg_write(`PCSIA_REG_TOP_HIGH, 8'h12);
    reg_check(`PCSIA_REG_STK_PTR, 8'h05);
    reg_check(`PCSIA_REG_TOP_LOW, 8'hAB);
    reg_check(`PCSIA_REG_TOP_HIGH, 8'h12);
  endtask : t_top_entry
  task automatic t_fault_reset();
    @(posedge clk);
    fault_en <= 1'b1;
    reg_write(`PCSIA_REG_STK_PTR, 8'h1F);
    reg_write(`PCSIA_REG_PWR_STAT, 8'h00);
    run(PCSIA_OP_RETURN, 11'h000, 8'h00, 15'h0000);
    check("underflow fault", 16'h0001, {15'h0000, fault_seen});
    reg_check(`PCSIA_REG_PWR_STAT, 8'h01);
    reg_write(`PCSIA_REG_PWR_STAT, 8'h00);
    reg_write(`PCSIA_REG_STK_PTR, 8'h0F);
    run(PCSIA_OP_CALL, 11'h055, 8'h00, 15'h0000);
    check("overflow fault", 16'h0001, {15'h0000, fault_seen});
    reg_check(`PCSIA_REG_PWR_STAT, 8'h02);
    reg_check(`PCSIA_REG_STK_PTR, 8'h1F);
    @(posedge clk);
    fault_en <= 1'b0;
  endtask : t_fault_reset
  // Flash costs one extra cycle over data memory
  task automatic t_indirect();
    access(1'b0, 16'h0123, 1'b0, 8'h00, mem_init(12'h123), 16'h0002);
    access(1'b1, 16'h20AA, 1'b0, 8'h00, mem_init(12'h12A), 16'h0002);
    access(1'b1, 16'h0040, 1'b1, 8'h3C, 8'h00, 16'h0002);
    access(1'b0, 16'h0040, 1'b0, 8'h00, 8'h3C, 16'h0002);
    access(1'b1, 16'h0081, 1'b0, 8'h00, 8'h00, 16'h0002);
    access(1'b0, 16'h1500, 1'b0, 8'h00, 8'h00, 16'h0002);
    access(1'b1, 16'h8155, 1'b0, 8'h00, 8'h55 ^ 8'h3C, 16'h0003);
    wr_before = wr_count;
    access(1'b0, 16'h0080, 1'b1, 8'h77, 8'h00, 16'h0002);
    access(1'b1, 16'h8155, 1'b1, 8'h77, 8'h00, 16'h0003);
    check("memory writes", wr_before, wr_count);
    access(1'b1, 16'h8155, 1'b0, 8'h00, 8'h55 ^ 8'h3C, 16'h0003);
  endtask : t_indirect
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    fault_en = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    cmd = '0;
    ind_req = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pc_flow();
    t_stack_wrap();
    t_top_entry();
    t_fault_reset();
    t_indirect();
    summarize();
  end
endmodule : pcsia_unit_bench
`default_nettype wire
